// [src/out_sel_pkg.sv]
// Constants for the programmable output terminal selector.
// Assumes a 10 MHz system clock and an APB master with 32-bit data.

package out_sel_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_SELECT = 8'h00;
   localparam logic [7:0] OFS_ARRIVAL = 8'h04;
   localparam logic [7:0] OFS_THRESH = 8'h08;
   localparam logic [7:0] OFS_LIMDLY = 8'h0C;
   localparam logic [7:0] OFS_TORQUE = 8'h10;
   localparam logic [7:0] OFS_COUNT = 8'h14;
   localparam logic [7:0] OFS_TIMER = 8'h18;
   localparam logic [7:0] OFS_HOURS = 8'h1C;
   localparam logic [7:0] OFS_UNDERLOAD = 8'h20;
   localparam logic [7:0] OFS_VBUS = 8'h24;
   localparam logic [7:0] OFS_OVERLOAD = 8'h28;
   localparam logic [7:0] OFS_STATUS = 8'h2C;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int SEL_RELAY_LSB = 8;
   localparam int HI_LSB = 16;
   localparam logic [5:0] RST_TRANS_SEL = 6'h00;
   localparam logic [5:0] RST_RELAY_SEL = 6'h13;
   localparam logic [15:0] RST_WIDTH = 16'h00FA;
   localparam logic [15:0] RST_LEVEL = 16'h1388;
   localparam logic [15:0] RST_LAG = 16'h0064;
   localparam logic [15:0] RST_LIM_DLY = 16'h0000;
   localparam logic [15:0] RST_TORQUE_REF = 16'h03E8;
   localparam logic [15:0] RST_COUNT_TGT = 16'h0000;
   localparam logic [15:0] RST_TIMER_TGT = 16'h0000;
   localparam logic [15:0] RST_HOURS = 16'hFFFA;
   localparam logic [15:0] RST_UL_LEVEL = 16'h0064;
   localparam logic [15:0] RST_UL_DLY = 16'h0032;
   localparam logic [15:0] RST_STALL = 16'h1900;
   localparam logic [15:0] RST_UNDERV = 16'h0BB8;
   localparam logic [15:0] RST_OVERLOAD = 16'h03E8;
   localparam logic [15:0] MAX_COUNT_TGT = 16'h270F;

   // ----------------------------------------------------------------
   // Function codes
   // ----------------------------------------------------------------
   localparam logic [5:0] FN_RUN = 6'h01;
   localparam logic [5:0] FN_ARRIVAL = 6'h02;
   localparam logic [5:0] FN_THRESH = 6'h03;
   localparam logic [5:0] FN_UPPER = 6'h04;
   localparam logic [5:0] FN_LOWER = 6'h05;
   localparam logic [5:0] FN_ZERO_RUN = 6'h07;
   localparam logic [5:0] FN_TIMER = 6'h0D;
   localparam logic [5:0] FN_COUNT = 6'h0E;
   localparam logic [5:0] FN_HOURS = 6'h0F;
   localparam logic [5:0] FN_TORQUE = 6'h10;
   localparam logic [5:0] FN_STALL = 6'h12;
   localparam logic [5:0] FN_FAULT = 6'h13;
   localparam logic [5:0] FN_EXT = 6'h14;
   localparam logic [5:0] FN_UNDERV = 6'h15;
   localparam logic [5:0] FN_OVERLOAD = 6'h17;
   localparam logic [5:0] FN_AI1 = 6'h18;
   localparam logic [5:0] FN_AI2 = 6'h19;
   localparam logic [5:0] FN_SLEEP = 6'h1D;
   localparam logic [5:0] FN_ZERO = 6'h1E;
   localparam logic [5:0] FN_DIR = 6'h21;
   localparam logic [5:0] FN_UNDERLOAD = 6'h23;
   localparam logic [5:0] FN_MULTI = 6'h24;
   localparam logic [5:0] FN_CTRL = 6'h25;
   localparam logic [5:0] FN_MAX = 6'h25;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int TICK_MS = 100;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int AI_FAULT_MS = 500;
   localparam logic [15:0] AI_FAULT_TICKS = 16'(AI_FAULT_MS / TICK_MS);
   localparam int HOUR_S = 3600;
   localparam int HOUR_TICKS = HOUR_S * 1000 / TICK_MS;
   localparam int MINUTE_S = 60;
   localparam logic [6:0] TMR_SEC_TICKS = 7'h01;
   localparam logic [6:0] TMR_MIN_TICKS = 7'(MINUTE_S * TMR_SEC_TICKS);

endpackage : out_sel_pkg

// [src/hold_qualifier.sv]
// Qualifies a condition that must hold for a number of ticks.
// Assumes tick is a one-cycle pulse on the same clock.
`timescale 1ns/1ps

module hold_qualifier #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Qualification
   input wire logic tick,
   input wire logic cond,
   input wire logic [W-1:0] limit,
   output logic done
);

   logic [W-1:0] cnt_ff;

   // The count restarts whenever the condition drops.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_ff <= '0;
      end else if (!cond) begin
         cnt_ff <= '0;
      end else if (tick && cnt_ff < limit) begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         done <= 1'b0;
      end else begin
         done <= cond && cnt_ff >= limit;
      end
   end

endmodule : hold_qualifier

// [src/out_terminal_select.sv]
// Status generator and selector for the transistor and relay outputs.
// Assumes drive measurements arrive on sys_clk; settings over APB.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps

module out_terminal_select #(
   parameter int TICK_CYCLES = out_sel_pkg::TICK_CYCLES,
   parameter int HOUR_TICKS = out_sel_pkg::HOUR_TICKS,
   parameter int MULTI_N = 4
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Frequencies in 0.01 Hz
   input wire logic [15:0] out_freq,
   input wire logic [15:0] set_freq,
   input wire logic [15:0] upper_freq,
   input wire logic [15:0] lower_freq,
   // Measurements
   input wire logic [15:0] bus_volt,
   input wire logic [15:0] out_current,
   input wire logic [15:0] torque,
   input wire logic [15:0] count_value,
   input wire logic [11:0] ai1_level,
   input wire logic [11:0] ai1_min,
   input wire logic [11:0] ai1_max,
   input wire logic [11:0] ai2_level,
   input wire logic [11:0] ai2_min,
   input wire logic [11:0] ai2_max,
   // Drive state
   input wire logic drive_running,
   input wire logic drive_fault,
   input wire logic external_fault_stop,
   input wire logic sleep_state,
   input wire logic direction_rev,
   input wire logic [MULTI_N-1:0] multi_step_in,
   input wire logic control_in,
   input wire logic timer_enable_in,
   input wire logic timer_unit_min,
   // Terminals
   output logic transistor_out,
   output logic relay_out
);

   // ----------------------------------------------------------------
   // Settings
   // ----------------------------------------------------------------
   logic [5:0] trans_sel_ff;
   logic [5:0] relay_sel_ff;
   logic [15:0] width_ff, level_ff, lag_ff, up_dly_ff, lo_dly_ff;
   logic [15:0] tq_ref_ff, cnt_tgt_ff, tmr_tgt_ff, hours_ff;
   logic [15:0] ul_level_ff, ul_dly_ff, stall_ff, underv_ff, ovl_ff;
   logic [31:0] status;
   logic [31:0] nxt_rdata;
   logic mapped;
   logic wr;

   assign wr = psel && penable && pready && pwrite;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         trans_sel_ff <= out_sel_pkg::RST_TRANS_SEL;
         relay_sel_ff <= out_sel_pkg::RST_RELAY_SEL;
      end else if (wr && paddr == out_sel_pkg::OFS_SELECT) begin
         // Codes above the top one leave the selector unchanged.
         if (pwdata[5:0] <= out_sel_pkg::FN_MAX) begin
            trans_sel_ff <= pwdata[5:0];
         end
         if (pwdata[out_sel_pkg::SEL_RELAY_LSB +: 6] <=
             out_sel_pkg::FN_MAX) begin
            relay_sel_ff <= pwdata[out_sel_pkg::SEL_RELAY_LSB +: 6];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         width_ff <= out_sel_pkg::RST_WIDTH;
         level_ff <= out_sel_pkg::RST_LEVEL;
         lag_ff <= out_sel_pkg::RST_LAG;
         up_dly_ff <= out_sel_pkg::RST_LIM_DLY;
         lo_dly_ff <= out_sel_pkg::RST_LIM_DLY;
         tq_ref_ff <= out_sel_pkg::RST_TORQUE_REF;
         cnt_tgt_ff <= out_sel_pkg::RST_COUNT_TGT;
         tmr_tgt_ff <= out_sel_pkg::RST_TIMER_TGT;
         hours_ff <= out_sel_pkg::RST_HOURS;
         ul_level_ff <= out_sel_pkg::RST_UL_LEVEL;
         ul_dly_ff <= out_sel_pkg::RST_UL_DLY;
         stall_ff <= out_sel_pkg::RST_STALL;
         underv_ff <= out_sel_pkg::RST_UNDERV;
         ovl_ff <= out_sel_pkg::RST_OVERLOAD;
      end else if (wr) begin
         unique case (paddr)
            out_sel_pkg::OFS_ARRIVAL: begin
               width_ff <= pwdata[15:0];
            end
            out_sel_pkg::OFS_THRESH: begin
               level_ff <= pwdata[15:0];
               lag_ff <= pwdata[out_sel_pkg::HI_LSB +: 16];
            end
            out_sel_pkg::OFS_LIMDLY: begin
               up_dly_ff <= pwdata[15:0];
               lo_dly_ff <= pwdata[out_sel_pkg::HI_LSB +: 16];
            end
            out_sel_pkg::OFS_TORQUE: begin
               tq_ref_ff <= pwdata[15:0];
            end
            out_sel_pkg::OFS_COUNT: begin
               if (pwdata[15:0] <= out_sel_pkg::MAX_COUNT_TGT) begin
                  cnt_tgt_ff <= pwdata[15:0];
               end
            end
            out_sel_pkg::OFS_TIMER: begin
               tmr_tgt_ff <= pwdata[15:0];
            end
            out_sel_pkg::OFS_HOURS: begin
               hours_ff <= pwdata[15:0];
            end
            out_sel_pkg::OFS_UNDERLOAD: begin
               ul_level_ff <= pwdata[15:0];
               ul_dly_ff <= pwdata[out_sel_pkg::HI_LSB +: 16];
            end
            out_sel_pkg::OFS_VBUS: begin
               stall_ff <= pwdata[15:0];
               underv_ff <= pwdata[out_sel_pkg::HI_LSB +: 16];
            end
            out_sel_pkg::OFS_OVERLOAD: begin
               ovl_ff <= pwdata[15:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------
   always_comb begin
      mapped = 1'b1;
      nxt_rdata = 32'h0000_0000;
      unique case (paddr)
         out_sel_pkg::OFS_SELECT: begin
            nxt_rdata = {18'h0, relay_sel_ff, 2'h0, trans_sel_ff};
         end
         out_sel_pkg::OFS_ARRIVAL: nxt_rdata = {16'h0, width_ff};
         out_sel_pkg::OFS_THRESH: nxt_rdata = {lag_ff, level_ff};
         out_sel_pkg::OFS_LIMDLY: nxt_rdata = {lo_dly_ff, up_dly_ff};
         out_sel_pkg::OFS_TORQUE: nxt_rdata = {16'h0, tq_ref_ff};
         out_sel_pkg::OFS_COUNT: nxt_rdata = {16'h0, cnt_tgt_ff};
         out_sel_pkg::OFS_TIMER: nxt_rdata = {16'h0, tmr_tgt_ff};
         out_sel_pkg::OFS_HOURS: nxt_rdata = {16'h0, hours_ff};
         out_sel_pkg::OFS_UNDERLOAD: nxt_rdata = {ul_dly_ff, ul_level_ff};
         out_sel_pkg::OFS_VBUS: nxt_rdata = {underv_ff, stall_ff};
         out_sel_pkg::OFS_OVERLOAD: nxt_rdata = {16'h0, ovl_ff};
         out_sel_pkg::OFS_STATUS: nxt_rdata = status;
         default: mapped = 1'b0;
      endcase
   end

   // The answer is prepared in the setup cycle and stands one cycle.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata <= (psel && !penable && !pwrite) ? nxt_rdata : 32'h0;
      end
   end

   // ----------------------------------------------------------------
   // Time base of 0.1 s
   // ----------------------------------------------------------------
   logic [$clog2(TICK_CYCLES)-1:0] pre_ff;
   logic tick_ff;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pre_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= pre_ff == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);
         if (pre_ff == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) begin
            pre_ff <= '0;
         end else begin
            pre_ff <= pre_ff + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Frequency indications
   // ----------------------------------------------------------------
   logic [16:0] f_diff;
   logic [16:0] release_lvl;
   logic arrival_ff, thresh_ff, upper_done, lower_done;

   assign f_diff = (out_freq >= set_freq) ? {1'b0, out_freq - set_freq}
                                          : {1'b0, set_freq - out_freq};
   assign release_lvl = {1'b0, level_ff} - {1'b0, lag_ff};

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         arrival_ff <= 1'b0;
      end else begin
         arrival_ff <= f_diff <= {1'b0, width_ff};
      end
   end

   // A lag larger than the level never releases, not even at zero.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         thresh_ff <= 1'b0;
      end else if (out_freq >= level_ff) begin
         thresh_ff <= 1'b1;
      end else if (!release_lvl[16] &&
                   {1'b0, out_freq} <= release_lvl) begin
         thresh_ff <= 1'b0;
      end
   end

   hold_qualifier #(.W(16)) upper_q (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .tick(tick_ff),
      .cond(set_freq >= upper_freq && out_freq >= upper_freq),
      .limit(up_dly_ff),
      .done(upper_done)
   );

   hold_qualifier #(.W(16)) lower_q (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .tick(tick_ff),
      .cond(set_freq <= lower_freq && out_freq <= lower_freq),
      .limit(lo_dly_ff),
      .done(lower_done)
   );

   // ----------------------------------------------------------------
   // Voltage, torque and load indications
   // ----------------------------------------------------------------
   logic stall_ind_ff, torque_ind_ff, underload_flag, ul_done;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         stall_ind_ff <= 1'b0;
      end else if (bus_volt >= stall_ff) begin
         stall_ind_ff <= 1'b1;
      end else if (21'(bus_volt) * 21'd20 < 21'(stall_ff) * 21'd19) begin
         stall_ind_ff <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         torque_ind_ff <= 1'b0;
      end else if (torque >= tq_ref_ff) begin
         torque_ind_ff <= 1'b1;
      end else if (19'(torque) * 19'd5 < 19'(tq_ref_ff) * 19'd4) begin
         torque_ind_ff <= 1'b0;
      end
   end

   hold_qualifier #(.W(16)) underload_q (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .tick(tick_ff),
      .cond(torque < ul_level_ff),
      .limit(ul_dly_ff),
      .done(ul_done)
   );

   // Equal torque neither sets nor clears the flag.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         underload_flag <= 1'b0;
      end else if (torque > ul_level_ff) begin
         underload_flag <= 1'b0;
      end else if (ul_done) begin
         underload_flag <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Analog channel faults
   // ----------------------------------------------------------------
   logic [1:0] ai_fault;
   logic [11:0] ai_lvl [2];
   logic [11:0] ai_lo [2];
   logic [11:0] ai_hi [2];

   assign ai_lvl = '{ai1_level, ai2_level};
   assign ai_lo = '{ai1_min, ai2_min};
   assign ai_hi = '{ai1_max, ai2_max};

   for (genvar i = 0; i < 2; i++) begin : g_ai
      hold_qualifier #(.W(16)) ai_q (
         .sys_clk(sys_clk),
         .nrst(nrst),
         .tick(tick_ff),
         .cond(ai_lvl[i] < ai_lo[i] || ai_lvl[i] > ai_hi[i]),
         .limit(out_sel_pkg::AI_FAULT_TICKS),
         .done(ai_fault[i])
      );
   end

   // ----------------------------------------------------------------
   // Timer and running hours
   // ----------------------------------------------------------------
   logic [6:0] tmr_pre_ff;
   logic [15:0] tmr_acc_ff;
   logic [$clog2(HOUR_TICKS)-1:0] hr_pre_ff;
   logic [15:0] hr_acc_ff;
   logic [6:0] tmr_step;

   assign tmr_step = timer_unit_min ? out_sel_pkg::TMR_MIN_TICKS
                                    : out_sel_pkg::TMR_SEC_TICKS;

   // Accumulation stops at the setpoint so the match holds.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tmr_pre_ff <= '0;
         tmr_acc_ff <= '0;
      end else if (!timer_enable_in) begin
         tmr_pre_ff <= '0;
         tmr_acc_ff <= '0;
      end else if (tick_ff && tmr_acc_ff != tmr_tgt_ff) begin
         if (tmr_pre_ff + 7'h01 >= tmr_step) begin
            tmr_pre_ff <= '0;
            tmr_acc_ff <= tmr_acc_ff + 1'b1;
         end else begin
            tmr_pre_ff <= tmr_pre_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         hr_pre_ff <= '0;
         hr_acc_ff <= '0;
      end else if (drive_running && tick_ff) begin
         if (hr_pre_ff == ($clog2(HOUR_TICKS))'(HOUR_TICKS - 1)) begin
            hr_pre_ff <= '0;
            if (hr_acc_ff != 16'hFFFF) begin
               hr_acc_ff <= hr_acc_ff + 1'b1;
            end
         end else begin
            hr_pre_ff <= hr_pre_ff + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Function table and selectors
   // ----------------------------------------------------------------
   logic [63:0] fn;

   always_comb begin
      fn = 64'h0;
      fn[out_sel_pkg::FN_RUN] = drive_running;
      fn[out_sel_pkg::FN_ARRIVAL] = arrival_ff;
      fn[out_sel_pkg::FN_THRESH] = thresh_ff;
      fn[out_sel_pkg::FN_UPPER] = upper_done;
      fn[out_sel_pkg::FN_LOWER] = lower_done;
      fn[out_sel_pkg::FN_ZERO_RUN] = drive_running && out_freq == 16'h0;
      fn[out_sel_pkg::FN_TIMER] = timer_enable_in &&
                                  tmr_acc_ff == tmr_tgt_ff;
      fn[out_sel_pkg::FN_COUNT] = count_value >= cnt_tgt_ff;
      fn[out_sel_pkg::FN_HOURS] = hr_acc_ff >= hours_ff;
      fn[out_sel_pkg::FN_TORQUE] = torque_ind_ff;
      fn[out_sel_pkg::FN_STALL] = stall_ind_ff;
      fn[out_sel_pkg::FN_FAULT] = drive_fault;
      fn[out_sel_pkg::FN_EXT] = external_fault_stop;
      fn[out_sel_pkg::FN_UNDERV] = bus_volt < underv_ff;
      fn[out_sel_pkg::FN_OVERLOAD] = out_current > ovl_ff;
      fn[out_sel_pkg::FN_AI1] = ai_fault[0];
      fn[out_sel_pkg::FN_AI2] = ai_fault[1];
      fn[out_sel_pkg::FN_SLEEP] = sleep_state;
      fn[out_sel_pkg::FN_ZERO] = out_freq == 16'h0;
      fn[out_sel_pkg::FN_DIR] = direction_rev;
      fn[out_sel_pkg::FN_UNDERLOAD] = underload_flag;
      fn[out_sel_pkg::FN_MULTI] = |multi_step_in;
      fn[out_sel_pkg::FN_CTRL] = control_in;
   end

   // Each terminal picks its own code from the shared table.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         transistor_out <= 1'b0;
         relay_out <= 1'b0;
      end else begin
         transistor_out <= fn[trans_sel_ff];
         relay_out <= fn[relay_sel_ff];
      end
   end

   assign status = {18'h0, ai_fault, underload_flag, fn[15:13],
                    torque_ind_ff, stall_ind_ff, lower_done, upper_done,
                    thresh_ff, arrival_ff, relay_out, transistor_out};

endmodule : out_terminal_select

// [tb/terminal_load.sv]
// Far-side model: a controller input latching both terminals.
// Assumes active-high terminal levels on sys_clk.
`timescale 1ns/1ps
module terminal_load (
   input wire logic sys_clk,
   input wire logic transistor_out,
   input wire logic relay_out,
   output logic [1:0] seen
);
   always_ff @(posedge sys_clk) begin
      seen <= {relay_out, transistor_out};
   end
endmodule : terminal_load

// [tb/out_sel_checker.sv]
// Port checker for the output terminal selector.
// Assumes select writes land at the APB access edge.
`timescale 1ns/1ps
module out_sel_checker #(
   parameter int MULTI_N = 4
) (
   input wire logic sys_clk, nrst, psel, penable, pwrite, pready,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [15:0] out_freq,
   input wire logic drive_fault, external_fault_stop, sleep_state,
   input wire logic direction_rev, control_in, transistor_out, relay_out,
   input wire logic [MULTI_N-1:0] multi_step_in
);
   logic [11:0] sel_ff, prev_ff;
   logic [1:0] up_ff;
   wire wr = psel && penable && pready && pwrite && paddr == 8'h00;
   wire ok = up_ff == 2'h3 && sel_ff == prev_ff;
   wire [5:0] tc = sel_ff[5:0];
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sel_ff <= 12'h4C0;
         prev_ff <= 12'h4C0;
         up_ff <= 2'h0;
      end else begin
         prev_ff <= sel_ff;
         up_ff <= up_ff + {1'b0, up_ff != 2'h3};
         if (wr && pwdata[5:0] <= 6'h25) sel_ff[5:0] <= pwdata[5:0];
         if (wr && pwdata[13:8] <= 6'h25) sel_ff[11:6] <= pwdata[13:8];
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   AST_FAULT: assert property (ok && sel_ff[11:6] == 6'h13
      |-> relay_out == $past(drive_fault)) else $error("fault");
   AST_EXT: assert property (ok && tc == 6'h14
      |-> transistor_out == $past(external_fault_stop)) else $error("ext");
   AST_SLEEP: assert property (ok && tc == 6'h1D
      |-> transistor_out == $past(sleep_state)) else $error("sleep");
   AST_ZERO: assert property (ok && tc == 6'h1E
      |-> transistor_out == ($past(out_freq) == 16'h0)) else $error("zero");
   AST_DIR: assert property (ok && tc == 6'h21
      |-> transistor_out == $past(direction_rev)) else $error("dir");
   AST_MULTI: assert property (ok && tc == 6'h24
      |-> transistor_out == |$past(multi_step_in)) else $error("multi");
   AST_CTRL: assert property (ok && tc == 6'h25
      |-> transistor_out == $past(control_in)) else $error("ctrl");
   AST_RSV: assert property (ok && tc inside {6'h16, 6'h1A, 6'h1B,
      6'h1C, 6'h1F, 6'h20, 6'h22} |-> !transistor_out) else $error("rsv");
endmodule : out_sel_checker
bind out_terminal_select out_sel_checker #(.MULTI_N(MULTI_N)) i_chk (
   .sys_clk, .nrst, .psel, .penable, .pwrite, .pready, .paddr, .pwdata,
   .out_freq, .drive_fault, .external_fault_stop, .sleep_state,
   .direction_rev, .control_in, .transistor_out, .relay_out, .multi_step_in
);

// [tb/out_terminal_select_tb.sv]
// Self-checking bench for the output terminal selector.
// Assumes the bound checker and the far-side latch model.
`timescale 1ns/1ps
module out_terminal_select_tb;
   logic sys_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, pslverr, err, transistor_out, relay_out;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] out_freq = 16'h1388, set_freq = 16'h0, bus_volt = 16'h1000;
   logic [15:0] out_current = 16'h0100, torque = 16'h0200, count_value = 16'h0;
   logic [11:0] ai1_level = 12'h800, ai2_level = 12'h800;
   logic [11:0] ai_lo = 12'h100, ai_hi = 12'hF00;
   logic [15:0] upper_freq = 16'hFFFF, lower_freq = 16'h0000;
   logic drive_fault = 1'b1, external_fault_stop = 1'b0, sleep_state = 1'b0;
   logic direction_rev = 1'b0, control_in = 1'b0;
   logic drive_running = 1'b0, timer_enable_in = 1'b0, timer_unit_min = 1'b0;
   logic [3:0] multi_step_in = 4'h0;
   logic [1:0] seen;
   int failures = 0, samples_checked = 0;
   always #50 sys_clk = ~sys_clk;
   out_terminal_select #(.TICK_CYCLES(10), .HOUR_TICKS(5)) i_dut (
      .sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .out_freq, .set_freq, .upper_freq,
      .lower_freq, .bus_volt, .out_current, .torque, .count_value,
      .ai1_level, .ai1_min(ai_lo), .ai1_max(ai_hi), .ai2_level,
      .ai2_min(ai_lo), .ai2_max(ai_hi), .drive_running,
      .drive_fault, .external_fault_stop, .sleep_state, .direction_rev,
      .multi_step_in, .control_in, .timer_enable_in,
      .timer_unit_min, .transistor_out, .relay_out);
   terminal_load i_load (.sys_clk, .transistor_out, .relay_out, .seen);
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic lvl(input int n, input logic [1:0] e);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
      cmp({30'h0, seen}, {30'h0, e});
      @(posedge sys_clk);
   endtask : lvl
   task automatic set_in(input logic [5:0] c, input logic on);
      case (c)
         6'h15: bus_volt <= on ? 16'h0100 : 16'h1000;
         6'h17: out_current <= on ? 16'h07D0 : 16'h0100;
         6'h1E: out_freq <= on ? 16'h0000 : 16'h1388;
         6'h21: direction_rev <= on;
         6'h24: multi_step_in <= on ? 4'h4 : 4'h0;
         default: begin
            external_fault_stop <= on;
            sleep_state <= on;
            control_in <= on;
         end
      endcase
   endtask : set_in
   task automatic t_regs;
      apb(1'b1, 8'h00, 32'h00001326);
      apb(1'b0, 8'h00, 32'h0);
      cmp(rd, 32'h00001300);
      lvl(1, 2'b10);
      drive_fault <= 1'b0;
      lvl(3, 2'b00);
      apb(1'b0, 8'h3C, 32'h0);
      cmp({rd[30:0], err}, 32'h1);
   endtask : t_regs
   task automatic t_direct;
      logic [5:0] c [13] = '{6'h14, 6'h15, 6'h17, 6'h1D, 6'h1E, 6'h21, 6'h24,
         6'h25, 6'h16, 6'h1A, 6'h1F, 6'h22, 6'h1C};
      for (int i = 0; i < 13; i++) begin
         apb(1'b1, 8'h00, {18'h0, 6'h13, 2'h0, c[i]});
         set_in(c[i], 1'b1);
         lvl(3, {1'b0, i < 8});
         set_in(c[i], 1'b0);
         lvl(3, 2'b00);
      end
   endtask : t_direct
   task automatic t_hyst;
      logic [63:0] t [5] = '{64'h0003_1324_1388_1356, 64'h0010_031F_03E8_0320,
         64'h0012_17BF_1900_17C0, 64'h000E_0004_0005_270F,
         64'h0002_0CE4_0C80_0B54};
      logic [15:0] v;
      set_freq <= 16'h0BB8;
      apb(1'b1, 8'h14, 32'h5);
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, 8'h00, {18'h0, 6'h13, 2'h0, t[i][53:48]});
         for (int k = 0; k < 4; k++) begin
            v = k % 3 == 0 ? t[i][47:32] : (k == 1 ? t[i][31:16] : t[i][15:0]);
            case (t[i][53:48])
               6'h0E: count_value <= v;
               6'h10: torque <= v;
               6'h12: bus_volt <= v;
               default: out_freq <= v;
            endcase
            lvl(4, {1'b0, k%3>0});
         end
      end
   endtask : t_hyst
   task automatic t_ai;
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, 8'h00, 32'h00001318 + i);
         if (i == 0) ai1_level <= 12'hF80;
         else ai2_level <= 12'h010;
         lvl(30, 2'b00);
         lvl(50, 2'b01);
      end
   endtask : t_ai
   task automatic t_time;
      apb(1'b1, 8'h00, 32'h00002304);
      apb(1'b1, 8'h0C, 32'h00000003);
      apb(1'b1, 8'h20, 32'h00020064);
      upper_freq <= 16'h0BB8;
      torque <= 16'h0010;
      lvl(10, 2'b00);
      lvl(60, 2'b11);
      upper_freq <= 16'hFFFF;
      torque <= 16'h0200;
      lvl(3, 2'b00);
      apb(1'b1, 8'h00, 32'h00000F0D);
      apb(1'b1, 8'h18, 32'h00000003);
      apb(1'b1, 8'h1C, 32'h00000001);
      timer_enable_in <= 1'b1;
      drive_running <= 1'b1;
      lvl(15, 2'b00);
      lvl(60, 2'b11);
      timer_enable_in <= 1'b0;
      lvl(2, 2'b10);
      apb(1'b0, 8'h2C, 32'h0);
      cmp(rd, 32'h00003402);
   endtask : t_time
   task automatic complete_run;
      if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run
   initial begin
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      t_regs();
      t_direct();
      t_hyst();
      t_ai();
      t_time();
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      complete_run();
   end
endmodule : out_terminal_select_tb
